// ==== rtl/pcg_pkg.sv ====
// Purpose: constants shared by the clock generator control logic
// Assumes: 25 MHz system clock
// Notes:   register map, field positions, divider ratios, timing
package pcg_pkg;
  // system clock and master reset timing
  localparam int unsigned CLK_PERIOD_PS  = 40000;           // 25 MHz period
  localparam int unsigned MDR_MIN_NS     = 1000;            // master reset minimum width
  localparam int unsigned MDR_MIN_CYC    = (MDR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MDR_CNT_W      = 6;               // width of the hold counter

  // register byte offsets
  localparam logic [3:0]  CFG_OFS        = 4'h0;            // configuration word
  localparam logic [3:0]  STAT_OFS       = 4'h4;            // live status word
  localparam logic [3:0]  ADDR_MASK      = 4'hC;            // word select bits

  // configuration field positions
  localparam int unsigned F_SRC_XTAL     = 0;               // 1 crystal, 0 external reference
  localparam int unsigned F_PLL_ON_N     = 1;               // 0 bypasses the pll
  localparam int unsigned F_MDR          = 2;               // master divider reset level
  localparam int unsigned F_OE_A         = 3;               // first output enable
  localparam int unsigned F_OE_B         = 4;               // second group enable
  localparam int unsigned F_FEEDBACK_DIVIDER_SELECT       = 5;               // feedback divider select
  localparam int unsigned F_SEL_A        = 6;               // first divider select, 2 bits
  localparam int unsigned F_SEL_B        = 8;               // second divider select, 2 bits
  localparam int unsigned CFG_W          = 10;              // used configuration bits
  localparam logic [CFG_W-1:0] CFG_RST   = 10'h01B;         // pin-default levels

  // divider ratios
  localparam int unsigned RATIO_W        = 5;
  localparam logic [RATIO_W-1:0] DIV_1   = 5'h01;
  localparam logic [RATIO_W-1:0] DIV_2   = 5'h02;
  localparam logic [RATIO_W-1:0] DIV_4   = 5'h04;
  localparam logic [RATIO_W-1:0] DIV_5   = 5'h05;
  localparam logic [RATIO_W-1:0] DIV_10  = 5'h0A;
  localparam logic [RATIO_W-1:0] DIV_24  = 5'h18;
  localparam logic [RATIO_W-1:0] DIV_25  = 5'h19;
  localparam logic [1:0] SEL_D10         = 2'h0;
  localparam logic [1:0] SEL_D2          = 2'h1;
  localparam logic [1:0] SEL_D4          = 2'h2;
  localparam logic [1:0] SEL_D5          = 2'h3;
endpackage

// ==== rtl/pcg_ctrl.sv ====
// Purpose: divider and gating control of a pll clock generator
// Assumes: source clocks arrive as one-cycle edge ticks synchronous to clk_i
// Notes:   each tick is one source edge; a ratio of n toggles every n ticks
`timescale 1ns/1ps

// edge-counting divider with clean stop and start at logic 0
module pcg_div
(
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // control
  input  wire logic                          tick_i,
  input  wire logic [pcg_pkg::RATIO_W-1:0]   ratio_i,
  input  wire logic                          en_i,
  // outputs
  output logic                               out_o,
  output logic                               out_n_o
);
  logic [pcg_pkg::RATIO_W-1:0] cnt_q;                 // edge counter
  logic                        run_q;                 // divider running
  logic                        wrap;                  // ratio reached

  assign wrap = (cnt_q >= ratio_i - pcg_pkg::DIV_1);

  // gate: stop only while low, restart from low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      run_q <= 1'b0;
    else if (!run_q)
      run_q <= en_i;
    else if (!en_i && !out_o)
      run_q <= 1'b0;
  end

  // counter and true/complement outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_q)
    begin
      cnt_q   <= '0;
      out_o   <= 1'b0;
      out_n_o <= 1'b1;
    end
    else if (tick_i && wrap && (out_o || en_i))       // no new high phase once disabled
    begin
      cnt_q   <= '0;
      out_o   <= ~out_o;
      out_n_o <= out_o;
    end
    else if (tick_i)
      cnt_q <= cnt_q + pcg_pkg::DIV_1;
  end
endmodule

module pcg_ctrl
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // source edge ticks
  input  wire logic        xtal_tick_i,
  input  wire logic        ref_tick_i,
  input  wire logic        vco_tick_i,
  // phase detector side
  output logic             pfd_ref_o,
  output logic             pfd_fb_o,
  // clock outputs
  output logic             first_clock_output_o,
  output logic             first_clock_output_n_o,
  output logic             second_group_output_0_o,
  output logic             second_group_output_0_n_o,
  output logic             second_group_output_1_o,
  output logic             second_group_output_1_n_o
);
  logic [pcg_pkg::CFG_W-1:0]    cfg_q;                // configuration register
  logic [pcg_pkg::MDR_CNT_W-1:0] mdr_cnt_q;           // master reset hold count
  logic                         div_rst_q;            // divider reset
  logic                         pfd_ref_q;            // forwarded reference level
  logic                         ref_tick;             // chosen reference edge
  logic                         div_tick;             // edge feeding output dividers
  logic                         bypass;               // pll bypassed
  logic [pcg_pkg::RATIO_W-1:0]  ratio_a;              // first divider ratio
  logic [pcg_pkg::RATIO_W-1:0]  ratio_b;              // second divider ratio
  logic [pcg_pkg::RATIO_W-1:0]  ratio_fb;             // feedback ratio
  logic                         hit;                  // access this cycle
  logic                         qb_n;                 // shared complement

  // select decode shared by both output dividers
  function automatic logic [pcg_pkg::RATIO_W-1:0] sel_ratio(input logic [1:0] s);
    logic [pcg_pkg::RATIO_W-1:0] r;
    r = pcg_pkg::DIV_10;
    unique case (s)
      pcg_pkg::SEL_D10: r = pcg_pkg::DIV_10;
      pcg_pkg::SEL_D2:  r = pcg_pkg::DIV_2;
      pcg_pkg::SEL_D4:  r = pcg_pkg::DIV_4;
      pcg_pkg::SEL_D5:  r = pcg_pkg::DIV_5;
    endcase
    return r;
  endfunction

  // source, bypass and ratio steering
  always_comb
  begin
    ref_tick = cfg_q[pcg_pkg::F_SRC_XTAL] ? xtal_tick_i : ref_tick_i;
    bypass   = !cfg_q[pcg_pkg::F_PLL_ON_N];
    div_tick = bypass ? ref_tick : vco_tick_i;
    ratio_a  = bypass ? pcg_pkg::DIV_1
                      : sel_ratio(cfg_q[pcg_pkg::F_SEL_A +: 2]);
    ratio_b  = bypass ? pcg_pkg::DIV_1
                      : sel_ratio(cfg_q[pcg_pkg::F_SEL_B +: 2]);
    ratio_fb = cfg_q[pcg_pkg::F_FEEDBACK_DIVIDER_SELECT] ? pcg_pkg::DIV_24
                                        : pcg_pkg::DIV_25;
  end

  assign hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // configuration write at the acknowledging edge, byte lanes 0 and 1
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_q <= pcg_pkg::CFG_RST;
    else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
             && ((wb_adr_i & pcg_pkg::ADDR_MASK) == pcg_pkg::CFG_OFS))
    begin
      if (wb_sel_i[0])
        cfg_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        cfg_q[pcg_pkg::CFG_W-1:8] <= wb_dat_i[pcg_pkg::CFG_W-1:8];
    end
  end

  // bus answer one cycle after request, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= hit;
      wb_dat_o <= '0;
      if (hit && ((wb_adr_i & pcg_pkg::ADDR_MASK) == pcg_pkg::CFG_OFS))
        wb_dat_o[pcg_pkg::CFG_W-1:0] <= cfg_q;
      else if (hit && ((wb_adr_i & pcg_pkg::ADDR_MASK) == pcg_pkg::STAT_OFS))
        wb_dat_o[6:0] <= {div_rst_q, bypass, pfd_fb_o, pfd_ref_q,
                          second_group_output_1_o, second_group_output_0_o,
                          first_clock_output_o};
    end
  end

  // master reset width filter and power-on divider reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mdr_cnt_q <= '0;
      div_rst_q <= 1'b1;
    end
    else if (!cfg_q[pcg_pkg::F_MDR])
    begin
      mdr_cnt_q <= '0;
      div_rst_q <= 1'b0;
    end
    else if (mdr_cnt_q < pcg_pkg::MDR_CNT_W'(pcg_pkg::MDR_MIN_CYC))
    begin
      mdr_cnt_q <= mdr_cnt_q + 1'b1;
      div_rst_q <= 1'b0;
    end
    else
      div_rst_q <= 1'b1;
  end

  // reference level forwarded to the phase detector
  always_ff @(posedge clk_i)
  begin
    if (rst_i || div_rst_q)
      pfd_ref_q <= 1'b0;
    else if (ref_tick)
      pfd_ref_q <= ~pfd_ref_q;
  end
  assign pfd_ref_o = pfd_ref_q;

  // feedback divider, vco to phase detector
  pcg_div u_fb
  (
    .clk_i   (clk_i),
    .rst_i   (div_rst_q),
    .tick_i  (vco_tick_i),
    .ratio_i (ratio_fb),
    .en_i    (1'b1),
    .out_o   (pfd_fb_o),
    .out_n_o ()
  );

  // first output divider
  pcg_div u_a
  (
    .clk_i   (clk_i),
    .rst_i   (div_rst_q),
    .tick_i  (div_tick),
    .ratio_i (ratio_a),
    .en_i    (cfg_q[pcg_pkg::F_OE_A]),
    .out_o   (first_clock_output_o),
    .out_n_o (first_clock_output_n_o)
  );

  // second divider drives both group outputs from one flop pair
  pcg_div u_b
  (
    .clk_i   (clk_i),
    .rst_i   (div_rst_q),
    .tick_i  (div_tick),
    .ratio_i (ratio_b),
    .en_i    (cfg_q[pcg_pkg::F_OE_B]),
    .out_o   (second_group_output_0_o),
    .out_n_o (qb_n)
  );
  assign second_group_output_1_o   = second_group_output_0_o;
  assign second_group_output_0_n_o = qb_n;
  assign second_group_output_1_n_o = qb_n;
endmodule

// ==== dv/pcg_src.sv ====
// Purpose: source-side model giving crystal, reference and vco edge ticks
// Assumes: one tick pulse per source edge, spacing in clk_i cycles
// Notes:   spacings are parameters with plain defaults
`timescale 1ns/1ps
module pcg_src
#(
  parameter int unsigned XP = 3, // crystal tick spacing
  parameter int unsigned RP = 5, // reference tick spacing
  parameter int unsigned VP = 2  // vco tick spacing
)
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // source edge ticks
  output logic      xtal_tick_o = 1'b0,
  output logic      ref_tick_o  = 1'b0,
  output logic      vco_tick_o  = 1'b0
);
  int unsigned cnt_q = 0; // free running cycle count
  // strictly periodic ticks, never faster than one a cycle
  always @(posedge clk_i)
  begin
    cnt_q       <= rst_i ? 0 : cnt_q + 1;
    xtal_tick_o <= !rst_i && (cnt_q % XP == 0);
    ref_tick_o  <= !rst_i && (cnt_q % RP == 0);
    vco_tick_o  <= !rst_i && (cnt_q % VP == 0);
  end
endmodule

// ==== dv/pcg_ctrl_asserts.sv ====
// Purpose: port-level checks of the clock generator control
// Assumes: one clk_i domain, rst_i synchronous active high
// Notes:   enable bits are tracked from configuration writes
`timescale 1ns/1ps
module pcg_ctrl_asserts
(
  // clock, reset and bus
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [3:0]  wb_adr_i, wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  // ticks and clock outputs
  input wire logic        xtal_tick_i, ref_tick_i, vco_tick_i, pfd_ref_o,
  input wire logic        first_clock_output_o, first_clock_output_n_o,
  input wire logic        second_group_output_0_o, second_group_output_0_n_o,
  input wire logic        second_group_output_1_o, second_group_output_1_n_o
);
  logic oe_a_q; // tracked first enable
  logic oe_b_q; // tracked group enable
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // follow enable bits as the configuration word is written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oe_a_q <= 1'b1;
      oe_b_q <= 1'b1;
    end
    else if (wb_ack_o && wb_cyc_i && wb_we_i && wb_sel_i[0] && wb_adr_i[3:2] == 2'h0)
    begin
      oe_a_q <= wb_dat_i[pcg_pkg::F_OE_A];
      oe_b_q <= wb_dat_i[pcg_pkg::F_OE_B];
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_cmp_a; first_clock_output_n_o == !first_clock_output_o; endproperty
  property p_grp;
    second_group_output_0_o == second_group_output_1_o && second_group_output_0_n_o ==
      second_group_output_1_n_o && second_group_output_0_n_o == !second_group_output_0_o;
  endproperty
  property p_off_a; (!oe_a_q) [*3] ##0 !first_clock_output_o |=> !first_clock_output_o;
  endproperty
  property p_off_b; (!oe_b_q) [*3] ##0 !second_group_output_0_o |=> !second_group_output_0_o;
  endproperty
  property p_rise_a;
    $rose(first_clock_output_o) |-> $past(vco_tick_i) || $past(ref_tick_i) || $past(xtal_tick_i);
  endproperty
  property p_ref; $rose(pfd_ref_o) |-> $past(xtal_tick_i) || $past(ref_tick_i); endproperty
  a_ack: assert property (p_ack) else $error("bus answer not a single cycle");
  a_dat: assert property (p_dat) else $error("read data not zero outside answer");
  a_cmp_a: assert property (p_cmp_a) else $error("first complement wrong");
  a_grp: assert property (p_grp) else $error("group outputs not aligned");
  a_off_a: assert property (p_off_a) else $error("disabled first output rose");
  a_off_b: assert property (p_off_b) else $error("disabled group output rose");
  a_rise_a: assert property (p_rise_a) else $error("first output rose without tick");
  a_ref: assert property (p_ref) else $error("reference level moved without tick");
endmodule
bind pcg_ctrl pcg_ctrl_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .xtal_tick_i, .ref_tick_i, .vco_tick_i, .pfd_ref_o,
  .first_clock_output_o, .first_clock_output_n_o, .second_group_output_0_o,
  .second_group_output_0_n_o, .second_group_output_1_o, .second_group_output_1_n_o);

// ==== dv/pcg_ctrl_test.sv ====
// Purpose: self-checking bench for the clock generator control
// Assumes: source model ticks every 3, 5 and 2 cycles
// Notes:   periods are measured in clk_i cycles between rising edges
`timescale 1ns/1ps
module pcg_ctrl_test;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, xt, rt, vt, pr, pf, fo, fon, b0, b0n, b1, b1n;
  int errors = 0, comparisons = 0, p;
  int div[4] = '{10, 2, 4, 5}; // select decode
  pcg_src u_src (.clk_i, .rst_i, .xtal_tick_o(xt), .ref_tick_o(rt), .vco_tick_o(vt));
  pcg_ctrl u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .xtal_tick_i(xt), .ref_tick_i(rt), .vco_tick_i(vt),
    .pfd_ref_o(pr), .pfd_fb_o(pf), .first_clock_output_o(fo), .first_clock_output_n_o(fon),
    .second_group_output_0_o(b0), .second_group_output_0_n_o(b0n),
    .second_group_output_1_o(b1), .second_group_output_1_n_o(b1n));
  initial forever #20 clk_i = !clk_i;
  task automatic stop_test();
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one classic cycle, held until the answer
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (n >= 20)
    begin
      errors++;
      stop_test();
    end
  endtask
  // cycles between two rising edges of the chosen output
  task automatic per(input int w);
    int n, k = 0;
    logic l, c;
    p = 0;
    #1;
    l = w == 0 ? fo : w == 1 ? b0 : w == 2 ? pf : pr;
    for (n = 0; n < 1000 && k < 2; n++)
    begin
      @(posedge clk_i);
      #1;
      c = w == 0 ? fo : w == 1 ? b0 : w == 2 ? pf : pr;
      p += (k > 0);
      k += (c && !l);
      l = c;
    end
    if (k < 2)
    begin
      errors++;
      stop_test();
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, 4'h0, 0);
    chk("cfg reset", 32'h01B, rd);
    bus(1, 4'h8, 32'h3FF);
    bus(0, 4'h8, 0);
    chk("unmapped", 32'h0, rd);
    bus(0, 4'h0, 0);
    chk("unmapped write", 32'h01B, rd);
    bus(1, 4'h0, 32'h003);
    repeat (200) @(posedge clk_i);
    for (int i = 0; i < 20; i++)
      @(negedge clk_i) chk("gated", 6'h15, {fo, fon, b0, b0n, b1, b1n});
    for (int s = 0; s < 4; s++)
    begin
      bus(1, 4'h0, 32'(((3 - s) << 8) | (s << 6) | ((s % 2) << 5) | 8'h1B));
      repeat (300) @(posedge clk_i);
      per(0);
      chk("first period", 4 * div[s], p);
      per(1);
      chk("group period", 4 * div[3 - s], p);
      per(2);
      chk("fb period", s % 2 ? 96 : 100, p);
      per(3);
      chk("xtal ref period", 6, p);
    end
    bus(1, 4'h0, 32'h018);
    repeat (100) @(posedge clk_i);
    per(0);
    chk("bypass first", 10, p);
    per(1);
    chk("bypass group", 10, p);
    per(3);
    chk("ext ref period", 10, p);
    bus(1, 4'h0, 32'h01F);
    bus(0, 4'h4, 0);
    chk("reset early", 32'h0, rd & 32'h40);
    repeat (40) @(posedge clk_i);
    bus(0, 4'h4, 0);
    chk("reset held", 32'h40, rd & 32'h47);
    bus(1, 4'h0, 32'h01B);
    repeat (100) @(posedge clk_i);
    per(0);
    chk("after reset", 40, p);
    stop_test();
  end
endmodule
